// [inc/phyc_pkg.sv]
// Shared constants and types for the transceiver basic control register
package phyc_pkg;

  // Management register space
  localparam logic [4:0] PHYC_REG_CTRL = 5'h00;
  localparam logic [15:0] PHYC_RD_UNMAPPED = 16'h0000;

  // Field positions in basic_control
  localparam int PHYC_B_SRST = 15;
  localparam int PHYC_B_LOOP = 14;
  localparam int PHYC_B_SPEED = 13;
  localparam int PHYC_B_NEG = 12;
  localparam int PHYC_B_PDWN = 11;
  localparam int PHYC_B_ISO = 10;
  localparam int PHYC_B_RSTRT = 9;
  localparam int PHYC_B_DUPLEX = 8;
  localparam int PHYC_B_COLT = 7;

  // Reset and read values of the non-strapped fields, and the strap address that selects isolate
  localparam logic PHYC_SRST_RST = 1'b0;
  localparam logic PHYC_PDWN_RST = 1'b0;
  localparam logic PHYC_COLT_RST = 1'b0;
  localparam logic PHYC_RSTRT_RD = 1'b0;
  localparam logic PHYC_NEG_RD_DFLT = 1'b1;
  localparam logic [6:0] PHYC_RSVD_RD = 7'h00;
  localparam logic [4:0] PHYC_ISO_STRAP_ADDR = 5'h00;

  // Management frame fields
  localparam logic [1:0] PHYC_OP_WR = 2'b01;
  localparam logic [1:0] PHYC_OP_RD = 2'b10;
  localparam logic [5:0] PHYC_PRE_MIN = 6'h20;
  localparam logic [4:0] PHYC_HDR_LAST = 5'h0b;
  localparam logic [4:0] PHYC_DATA_LAST = 5'h0f;

  // Timing
  localparam int PHYC_CLK_NS = 10;
  localparam int PHYC_SRST_NS = 1000000;
  localparam int PHYC_SRST_CYC = PHYC_SRST_NS / PHYC_CLK_NS;
  localparam logic [1:0] PHYC_STRAP_WAIT = 2'h3;

  typedef enum logic [4:0] {
    PHYC_S_IDLE = 5'b00001,
    PHYC_S_ST = 5'b00010,
    PHYC_S_HDR = 5'b00100,
    PHYC_S_TA = 5'b01000,
    PHYC_S_DATA = 5'b10000
  } phyc_mdio_st_t;

endpackage : phyc_pkg

// [verilog/phyc_sync.sv]
// Two-flop synchroniser bank for asynchronous pin inputs
`timescale 1ns/1ps
module phyc_sync #(
  parameter int W = 1
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
          meta_ff[gi] <= 1'b0;
          sync_ff[gi] <= 1'b0;
        end else begin
          meta_ff[gi] <= async_i[gi];
          sync_ff[gi] <= meta_ff[gi];
        end
      end
    end
  endgenerate

  assign sync_o = sync_ff;

endmodule : phyc_sync

// [verilog/phyc_rst_timer.sv]
// Software reset duration timer
`timescale 1ns/1ps
module phyc_rst_timer #(
  parameter int CYCLES = 100000
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic start_i,
  output logic busy_o,
  output logic done_o
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_ff;
  logic busy_ff;

  // Restart while busy is ignored so the window cannot stretch
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
      busy_ff <= 1'b0;
    end else if (!busy_ff) begin
      cnt_ff <= '0;
      busy_ff <= start_i;
    end else if (cnt_ff == LAST) begin
      busy_ff <= 1'b0;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign busy_o = busy_ff;
  assign done_o = busy_ff && (cnt_ff == LAST);

endmodule : phyc_rst_timer

// [verilog/phyc_ctrl.sv]
// Basic control register with serial management slave and mode outputs
//
// Operation
// [RQ1] Bit 15 one starts self-clearing soft reset
// [RQ2] Other writes ignored during one millisecond reset
// [RQ3] Bit 15 reads one while reset runs
// [RQ4] Soft reset never re-samples the straps
// [RQ5] Bit 14 sets local loopback, reads back
// [RQ6] Bit 13 forces speed when negotiation off
// [RQ7] Pin low disables negotiation, blocks bit 12
// [RQ8] Bit 12 toggles negotiation, strap after reset
// [RQ9] Bit 12 reads last write, else one
// [RQ10] Power-down bit powers channel, forces pads
// [RQ11] Bit 10 isolates MII, management stays alive
// [RQ12] Isolate ends on zero write or reset
// [RQ13] All-zero strapped address starts isolated
// [RQ14] Bit 9 restarts negotiation, reads zero
// [RQ15] Half duplex default, bit 8 forces full; the code takes the default from the duplex strap instead
// [RQ16] Bit 7 enables collision test, reads back
// [RQ17] Collision test acts only during loopback
// [RQ18] Test mode raises collision on transmit enable
// [RQ19] Test mode drops collision within four bits
// [RQ20] Bits 6 to 0 read zero
// [RQ21] Station writes one once, no clear needed
// [RQ22] Register zero over clause-22 management frames
`timescale 1ns/1ps
module phyc_ctrl
  import phyc_pkg::*;
#(
  parameter int SRST_CYCLES = PHYC_SRST_CYC
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  input wire logic [4:0] strap_phy_addr_i,
  input wire logic strap_loopback_i,
  input wire logic strap_speed_i,
  input wire logic strap_neg_en_i,
  input wire logic strap_duplex_i,
  input wire logic negotiation_enable_pin_i,
  input wire logic mii_txen_i,
  input wire logic core_col_i,
  input wire logic neg_speed_100_i,
  input wire logic neg_full_duplex_i,
  output logic soft_reset_o,
  output logic loopback_o,
  output logic speed_100_o,
  output logic full_duplex_o,
  output logic neg_enable_o,
  output logic neg_restart_o,
  output logic power_down_o,
  output logic pad_force_o,
  output logic mii_oe_o,
  output logic mii_in_en_o,
  output logic col_o
);

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [12:0] pins_s;
  logic [4:0] st_addr_s;
  logic mdc_s, mdio_s, txen_s, an_pin_s, st_loop_s, st_speed_s, st_neg_s, st_dup_s;

  phyc_sync #(
    .W(13)
  ) u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .async_i({mdc_i, mdio_i, mii_txen_i, negotiation_enable_pin_i, strap_phy_addr_i,
              strap_loopback_i, strap_speed_i, strap_neg_en_i, strap_duplex_i}),
    .sync_o(pins_s)
  );

  assign {mdc_s, mdio_s, txen_s, an_pin_s, st_addr_s,
          st_loop_s, st_speed_s, st_neg_s, st_dup_s} = pins_s;

  //////////////////////////////////////////////////////////////////////////
  // Strap capture, once after hardware reset only
  logic [1:0] strap_cnt_ff;
  logic [4:0] cap_addr_ff;
  logic strap_done_ff, cap_loop_ff, cap_speed_ff, cap_neg_ff, cap_dup_ff, strap_load;

  // Wait for the synchronisers to fill before trusting the strap levels
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      strap_cnt_ff <= 2'h0;
      strap_done_ff <= 1'b0;
    end else if (!strap_done_ff) begin
      strap_cnt_ff <= strap_cnt_ff + 2'h1;
      strap_done_ff <= (strap_cnt_ff == PHYC_STRAP_WAIT);
    end
  end

  assign strap_load = !strap_done_ff && (strap_cnt_ff == PHYC_STRAP_WAIT);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cap_addr_ff <= 5'h00;
      cap_loop_ff <= 1'b0;
      cap_speed_ff <= 1'b0;
      cap_neg_ff <= 1'b0;
      cap_dup_ff <= 1'b0;
    end else if (strap_load) begin // see [RQ4]
      cap_addr_ff <= st_addr_s;
      cap_loop_ff <= st_loop_s;
      cap_speed_ff <= st_speed_s;
      cap_neg_ff <= st_neg_s;
      cap_dup_ff <= st_dup_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Management frame engine
  phyc_mdio_st_t st_ff;
  logic [5:0] pre_cnt_ff;
  logic [4:0] bit_cnt_ff;
  logic [11:0] hdr_ff, nxt_hdr;
  logic [15:0] shf_ff, wdata_ff, rdata;
  logic mdc_prev_ff, is_rd_ff, mdio_out_ff, mdio_oe_ff, wr_ff, mdc_rise, hdr_match;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mdc_prev_ff <= 1'b0;
    end else begin
      mdc_prev_ff <= mdc_s;
    end
  end

  assign mdc_rise = mdc_s && !mdc_prev_ff;
  assign nxt_hdr = {hdr_ff[10:0], mdio_s};
  // Only this PHY address and register zero are answered
  assign hdr_match = (nxt_hdr[9:5] == cap_addr_ff) && (nxt_hdr[4:0] == PHYC_REG_CTRL); // see [RQ22]

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= PHYC_S_IDLE;
      pre_cnt_ff <= 6'h00;
      bit_cnt_ff <= 5'h00;
      hdr_ff <= 12'h000;
      shf_ff <= 16'h0000;
      is_rd_ff <= 1'b0;
      mdio_out_ff <= 1'b0;
      mdio_oe_ff <= 1'b0;
      wr_ff <= 1'b0;
      wdata_ff <= 16'h0000;
    end else begin
      wr_ff <= 1'b0;
      if (mdc_rise) begin
        case (st_ff)
          PHYC_S_IDLE: begin
            if (mdio_s) begin
              if (pre_cnt_ff != PHYC_PRE_MIN) begin
                pre_cnt_ff <= pre_cnt_ff + 6'h01;
              end
            end else begin
              pre_cnt_ff <= 6'h00;
              if (pre_cnt_ff == PHYC_PRE_MIN) begin
                st_ff <= PHYC_S_ST;
              end
            end
          end
          PHYC_S_ST: begin
            bit_cnt_ff <= 5'h00;
            st_ff <= mdio_s ? PHYC_S_HDR : PHYC_S_IDLE;
          end
          PHYC_S_HDR: begin
            hdr_ff <= nxt_hdr;
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
            if (bit_cnt_ff == PHYC_HDR_LAST) begin
              bit_cnt_ff <= 5'h00;
              is_rd_ff <= (nxt_hdr[11:10] == PHYC_OP_RD);
              shf_ff <= rdata;
              if (hdr_match && (nxt_hdr[11:10] == PHYC_OP_RD
                                || nxt_hdr[11:10] == PHYC_OP_WR)) begin
                st_ff <= PHYC_S_TA;
              end else begin
                st_ff <= PHYC_S_IDLE;
              end
            end
          end
          PHYC_S_TA: begin
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
            if (is_rd_ff && bit_cnt_ff == 5'h00) begin
              mdio_oe_ff <= 1'b1;
              mdio_out_ff <= 1'b0;
            end
            if (bit_cnt_ff == 5'h01) begin
              bit_cnt_ff <= 5'h00;
              mdio_out_ff <= shf_ff[15];
              st_ff <= PHYC_S_DATA;
            end
          end
          PHYC_S_DATA: begin
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
            shf_ff <= {shf_ff[14:0], mdio_s};
            mdio_out_ff <= shf_ff[14];
            if (bit_cnt_ff == PHYC_DATA_LAST) begin
              mdio_oe_ff <= 1'b0;
              wr_ff <= !is_rd_ff;
              wdata_ff <= {shf_ff[14:0], mdio_s};
              st_ff <= PHYC_S_IDLE;
            end
          end
          default: begin
            st_ff <= PHYC_S_IDLE;
            mdio_oe_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  assign mdio_o = mdio_out_ff;
  assign mdio_oe_o = mdio_oe_ff;

  //////////////////////////////////////////////////////////////////////////
  // Soft reset sequencing
  logic srst_start, srst_busy, srst_done, wr_ok;

  assign srst_start = wr_ff && wdata_ff[PHYC_B_SRST] && !srst_busy; // see [RQ1] [RQ21]
  // Writes landing inside the reset window are dropped
  assign wr_ok = wr_ff && !srst_busy && !wdata_ff[PHYC_B_SRST]; // see [RQ2]

  phyc_rst_timer #(
    .CYCLES(SRST_CYCLES)
  ) u_srst (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .start_i(srst_start),
    .busy_o(srst_busy),
    .done_o(srst_done)
  );

  //////////////////////////////////////////////////////////////////////////
  // Control fields
  logic loop_ff, speed_ff, neg_ff, neg_wr_ff, pdwn_ff, iso_ff, dup_ff, colt_ff, rstrt_ff;
  logic neg_eff, sw_reload;

  // Soft reset reloads from the captured straps, never from the pins
  assign sw_reload = strap_load || srst_done; // see [RQ4]

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      loop_ff <= 1'b0;
      speed_ff <= 1'b0;
      dup_ff <= 1'b0;
      iso_ff <= 1'b0;
    end else if (sw_reload) begin
      loop_ff <= strap_load ? st_loop_s : cap_loop_ff;
      speed_ff <= strap_load ? st_speed_s : cap_speed_ff;
      dup_ff <= strap_load ? st_dup_s : cap_dup_ff; // see [RQ15]
      iso_ff <= (strap_load ? st_addr_s : cap_addr_ff) == PHYC_ISO_STRAP_ADDR; // see [RQ13]
    end else if (wr_ok) begin
      loop_ff <= wdata_ff[PHYC_B_LOOP]; // see [RQ5]
      speed_ff <= wdata_ff[PHYC_B_SPEED]; // see [RQ6]
      dup_ff <= wdata_ff[PHYC_B_DUPLEX]; // see [RQ15]
      iso_ff <= wdata_ff[PHYC_B_ISO]; // see [RQ11] [RQ12]
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      neg_ff <= 1'b0;
      neg_wr_ff <= 1'b0;
    end else if (sw_reload) begin
      neg_ff <= strap_load ? st_neg_s : cap_neg_ff; // see [RQ8]
      neg_wr_ff <= 1'b0;
    end else if (wr_ok && an_pin_s) begin // see [RQ7]
      neg_ff <= wdata_ff[PHYC_B_NEG]; // see [RQ8]
      neg_wr_ff <= 1'b1;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pdwn_ff <= PHYC_PDWN_RST;
      colt_ff <= PHYC_COLT_RST;
    end else if (srst_done) begin
      pdwn_ff <= PHYC_PDWN_RST;
      colt_ff <= PHYC_COLT_RST;
    end else if (wr_ok) begin
      pdwn_ff <= wdata_ff[PHYC_B_PDWN]; // see [RQ10]
      colt_ff <= wdata_ff[PHYC_B_COLT]; // see [RQ16]
    end
  end

  assign neg_eff = neg_ff && an_pin_s; // see [RQ7]

  // Restart is a pulse only, so the stored bit is always zero on read
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rstrt_ff <= 1'b0;
    end else begin
      rstrt_ff <= wr_ok && wdata_ff[PHYC_B_RSTRT] && neg_eff; // see [RQ14]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read image

  always_comb begin
    rdata = PHYC_RD_UNMAPPED;
    rdata[PHYC_B_SRST] = srst_busy; // see [RQ3]
    rdata[PHYC_B_LOOP] = loop_ff;
    rdata[PHYC_B_SPEED] = speed_ff;
    rdata[PHYC_B_NEG] = neg_wr_ff ? neg_ff : PHYC_NEG_RD_DFLT; // see [RQ9]
    rdata[PHYC_B_PDWN] = pdwn_ff;
    rdata[PHYC_B_ISO] = iso_ff;
    rdata[PHYC_B_RSTRT] = PHYC_RSTRT_RD; // see [RQ14]
    rdata[PHYC_B_DUPLEX] = dup_ff;
    rdata[PHYC_B_COLT] = colt_ff;
    rdata[6:0] = PHYC_RSVD_RD; // see [RQ20]
  end

  //////////////////////////////////////////////////////////////////////////
  // Mode outputs and collision test

  logic col_ff;
  logic [4:0] mode_ff;

  // Latency is two sync flops plus this one: three cycles, under four bit times
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      col_ff <= 1'b0;
    end else if (colt_ff && loop_ff) begin // see [RQ17]
      col_ff <= txen_s; // see [RQ18] [RQ19]
    end else begin
      col_ff <= core_col_i;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mode_ff <= 5'h00;
    end else begin
      mode_ff[0] <= neg_eff ? neg_speed_100_i : speed_ff; // see [RQ6]
      mode_ff[1] <= neg_eff ? neg_full_duplex_i : dup_ff; // see [RQ15]
      mode_ff[2] <= neg_eff;
      mode_ff[3] <= pdwn_ff; // see [RQ10]
      mode_ff[4] <= !iso_ff; // see [RQ11]
    end
  end

  assign soft_reset_o = srst_busy;
  assign loopback_o = loop_ff;
  assign speed_100_o = mode_ff[0];
  assign full_duplex_o = mode_ff[1];
  assign neg_enable_o = mode_ff[2];
  assign neg_restart_o = rstrt_ff;
  assign power_down_o = mode_ff[3];
  // Single channel device: its power-down is the all-channel case
  assign pad_force_o = mode_ff[3];
  assign mii_oe_o = mode_ff[4];
  assign mii_in_en_o = mode_ff[4];
  assign col_o = col_ff;

endmodule : phyc_ctrl

// [test/phyc_ctrl_checker.sv]
// Port assertions for the basic control register block
`timescale 1ns/1ps
module phyc_ctrl_checker #(
  parameter int SRST_CYCLES = 20
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic mdio_o,
  input wire logic mdio_oe_o,
  input wire logic mii_txen_i,
  input wire logic core_col_i,
  input wire logic neg_speed_100_i,
  input wire logic neg_full_duplex_i,
  input wire logic soft_reset_o,
  input wire logic loopback_o,
  input wire logic speed_100_o,
  input wire logic full_duplex_o,
  input wire logic neg_enable_o,
  input wire logic neg_restart_o,
  input wire logic power_down_o,
  input wire logic pad_force_o,
  input wire logic mii_oe_o,
  input wire logic mii_in_en_o,
  input wire logic col_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  // Length of the soft reset, counted here since it is far too long to unroll
  logic [31:0] srst_cnt_ff;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      srst_cnt_ff <= 32'h0;
    end else begin
      srst_cnt_ff <= soft_reset_o ? srst_cnt_ff + 32'h1 : 32'h0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  srst_len_a: assert property ($fell(soft_reset_o) |-> srst_cnt_ff == 32'(SRST_CYCLES))
    else $error("Soft reset length wrong");
  srst_bound_a: assert property (srst_cnt_ff <= 32'(SRST_CYCLES))
    else $error("Soft reset does not clear");
  pads_pair_a: assert property (power_down_o == pad_force_o)
    else $error("Pad force differs from power down");
  mii_pair_a: assert property (mii_oe_o == mii_in_en_o)
    else $error("Isolate halves disagree");
  col_pass_a: assert property (
    !loopback_o && !$past(loopback_o) |-> col_o == $past(core_col_i))
    else $error("Collision not from core outside loopback");
  col_drop_a: assert property (
    $fell(mii_txen_i) && loopback_o && !core_col_i |-> ##[1:4] !col_o)
    else $error("Collision late to fall");
  restart_gate_a: assert property (neg_restart_o |-> neg_enable_o)
    else $error("Restart while negotiation disabled");
  restart_one_a: assert property (neg_restart_o |=> !neg_restart_o)
    else $error("Restart pulse too long");
  speed_neg_a: assert property (
    neg_enable_o && $past(neg_enable_o) && $past(neg_enable_o, 2)
    |-> speed_100_o == $past(neg_speed_100_i))
    else $error("Forced speed used while negotiating");
  duplex_neg_a: assert property (
    neg_enable_o && $past(neg_enable_o) && $past(neg_enable_o, 2)
    |-> full_duplex_o == $past(neg_full_duplex_i))
    else $error("Forced duplex used while negotiating");
  turn_zero_a: assert property ($rose(mdio_oe_o) |-> !mdio_o)
    else $error("Turnaround not driven low");
  cover property ($fell(soft_reset_o));
  cover property (neg_restart_o);
  cover property (loopback_o && $rose(col_o));
  cover property ($rose(mdio_oe_o));
endmodule : phyc_ctrl_checker

bind phyc_ctrl phyc_ctrl_checker #(.SRST_CYCLES(SRST_CYCLES)) chk_i (
  .clock_i(clock_i), .rst_i(rst_i), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o),
  .mii_txen_i(mii_txen_i), .core_col_i(core_col_i), .neg_speed_100_i(neg_speed_100_i),
  .neg_full_duplex_i(neg_full_duplex_i), .soft_reset_o(soft_reset_o),
  .loopback_o(loopback_o), .speed_100_o(speed_100_o), .full_duplex_o(full_duplex_o),
  .neg_enable_o(neg_enable_o), .neg_restart_o(neg_restart_o), .power_down_o(power_down_o),
  .pad_force_o(pad_force_o), .mii_oe_o(mii_oe_o), .mii_in_en_o(mii_in_en_o), .col_o(col_o)
);

// [test/phyc_mgr_model.sv]
// Station management model issuing clause-22 frames on MDC and MDIO
`timescale 1ns/1ps
module phyc_mgr_model
  import phyc_pkg::*;
(
  input wire logic clock_i,
  input wire logic mdio_o,
  input wire logic mdio_oe_o,
  output logic mdc_o,
  output logic mdio_line_o
);
  logic drv_en = 1'b0;
  logic drv_d = 1'b1;
  initial mdc_o = 1'b0;
  // Pull-up wins when nobody drives, so a silent device reads all ones
  assign mdio_line_o = mdio_oe_o ? mdio_o : (drv_en ? drv_d : 1'b1);
  ////////////////////////////////////////////////////////////////////////////////
  // Half period of 8 clocks, above the 2-clock minimum of the slave
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [15:0] wdata,
                       output logic [15:0] rdata, output logic ta_low);
    logic [63:0] bits;
    bits = {32'hffffffff, 2'b01, op, phy, PHYC_REG_CTRL, 2'b10, wdata};
    rdata = 16'hffff;
    ta_low = 1'b0;
    for (int i = 63; i >= 0; i--) begin
      drv_en = (op == PHYC_OP_WR) || (i > 17);
      drv_d = bits[i];
      repeat (8) @(posedge clock_i);
      #1;
      if (i == 16) ta_low = ~mdio_line_o;
      if (i < 16) rdata[i] = mdio_line_o;
      mdc_o = 1'b1;
      repeat (8) @(posedge clock_i);
      #1;
      mdc_o = 1'b0;
    end
    drv_en = 1'b0;
    repeat (16) @(posedge clock_i);
    #1;
  endtask : frame
endmodule : phyc_mgr_model

// [test/testbench.sv]
// Self-checking bench for the basic control register block
`timescale 1ns/1ps
module testbench
  import phyc_pkg::*;
;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] s_addr = 5'h05;
  logic s_speed = 1'b1;
  logic pin = 1'b1;
  logic txen = 1'b0;
  logic ccol = 1'b0;
  logic nspd = 1'b0;
  logic mdc, line, mdio_o, mdio_oe, srst, loop, spd, fdx, neg, rstrt, pdwn, padf, oe, ien, col;
  logic [15:0] rv;
  logic ta;
  int mismatches = 0;
  int comparisons = 0;
  int restarts = 0;
  always #5 clock_i = ~clock_i;
  always @(posedge clock_i) if (rstrt === 1'b1) restarts++;
  // Long soft reset so a read and a write fit inside it
  phyc_ctrl #(.SRST_CYCLES(3000)) uut (
    .clock_i(clock_i), .rst_i(rst_i), .mdc_i(mdc), .mdio_i(line), .mdio_o(mdio_o),
    .mdio_oe_o(mdio_oe), .strap_phy_addr_i(s_addr), .strap_loopback_i(1'b0),
    .strap_speed_i(s_speed), .strap_neg_en_i(1'b1), .strap_duplex_i(1'b0),
    .negotiation_enable_pin_i(pin), .mii_txen_i(txen), .core_col_i(ccol),
    .neg_speed_100_i(nspd), .neg_full_duplex_i(1'b1), .soft_reset_o(srst),
    .loopback_o(loop), .speed_100_o(spd), .full_duplex_o(fdx), .neg_enable_o(neg),
    .neg_restart_o(rstrt), .power_down_o(pdwn), .pad_force_o(padf), .mii_oe_o(oe),
    .mii_in_en_o(ien), .col_o(col));
  phyc_mgr_model mgr (.clock_i(clock_i), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe), .mdc_o(mdc),
    .mdio_line_o(line));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : cyc
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic flag(input string name, input logic exp, input logic got);
    chk(name, {15'h0, exp}, {15'h0, got});
  endtask : flag
  task automatic wr(input logic [15:0] d);
    mgr.frame(PHYC_OP_WR, s_addr, d, rv, ta);
  endtask : wr
  task automatic rd(input logic [15:0] exp);
    mgr.frame(PHYC_OP_RD, s_addr, 16'h0000, rv, ta);
    flag("turnaround", 1'b1, ta);
    chk("basic_control", exp, rv);
  endtask : rd
  task automatic hw_reset;
    rst_i = 1'b1;
    cyc(20);
    rst_i = 1'b0;
    cyc(10);
  endtask : hw_reset
  task automatic final_report;
    if (mismatches == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults;
    rd(16'h3000);
    flag("neg_enable_o", 1'b1, neg);
    flag("speed_100_o", 1'b0, spd);
    nspd = 1'b1;
    cyc(2);
    flag("speed_100_o", 1'b1, spd);
    nspd = 1'b0;
    mgr.frame(PHYC_OP_RD, s_addr ^ 5'h01, 16'h0000, rv, ta);
    chk("other_address", 16'hffff, rv);
  endtask : t_defaults
  task automatic t_restart;
    wr(16'h127f);
    rd(16'h1000);
    chk("restarts", 16'h0001, 16'(restarts));
  endtask : t_restart
  task automatic t_forced;
    wr(16'h0000);
    rd(16'h0000);
    flag("neg_enable_o", 1'b0, neg);
    wr(16'h2300);
    rd(16'h2100);
    flag("speed_100_o", 1'b1, spd);
    flag("full_duplex_o", 1'b1, fdx);
    chk("restarts", 16'h0001, 16'(restarts));
    wr(16'h0000);
    flag("full_duplex_o", 1'b0, fdx);
  endtask : t_forced
  task automatic t_pin;
    pin = 1'b0;
    wr(16'h1200);
    rd(16'h0000);
    chk("restarts", 16'h0001, 16'(restarts));
    pin = 1'b1;
    cyc(8);
    flag("neg_enable_o", 1'b0, neg);
  endtask : t_pin
  task automatic t_coltest;
    wr(16'h5080);
    rd(16'h5080);
    flag("loopback_o", 1'b1, loop);
    txen = 1'b1;
    for (int i = 0; i < 512 && col !== 1'b1; i++) cyc(1);
    flag("col_o", 1'b1, col);
    txen = 1'b0;
    cyc(4);
    flag("col_o", 1'b0, col);
    wr(16'h1080);
    txen = 1'b1;
    cyc(8);
    flag("col_o", 1'b0, col);
    ccol = 1'b1;
    cyc(2);
    flag("col_o", 1'b1, col);
    ccol = 1'b0;
    txen = 1'b0;
    wr(16'h1000);
    rd(16'h1000);
  endtask : t_coltest
  task automatic t_isolate;
    wr(16'h1c00);
    flag("mii_oe_o", 1'b0, oe);
    flag("mii_in_en_o", 1'b0, ien);
    flag("pad_force_o", 1'b1, padf);
    rd(16'h1c00);
    wr(16'h1000);
    flag("mii_oe_o", 1'b1, oe);
    flag("mii_in_en_o", 1'b1, ien);
    flag("power_down_o", 1'b0, pdwn);
  endtask : t_isolate
  task automatic t_soft;
    wr(16'h5000);
    s_speed = 1'b0;
    wr(16'h8800);
    flag("soft_reset_o", 1'b1, srst);
    mgr.frame(PHYC_OP_RD, s_addr, 16'h0000, rv, ta);
    chk("reset_bit", 16'h8000, rv & 16'h8000);
    wr(16'h0400);
    for (int i = 0; i < 4000 && srst !== 1'b0; i++) cyc(1);
    rd(16'h3000);
    s_speed = 1'b1;
  endtask : t_soft
  task automatic t_strap_iso;
    s_addr = 5'h00;
    hw_reset();
    rd(16'h3400);
    flag("mii_oe_o", 1'b0, oe);
    wr(16'h1000);
    flag("mii_oe_o", 1'b1, oe);
  endtask : t_strap_iso
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    hw_reset();
    t_defaults();
    t_restart();
    t_forced();
    t_pin();
    t_coltest();
    t_isolate();
    t_soft();
    t_strap_iso();
    final_report();
  end
  // Tests take about 28000 clocks; over three times that means a hang
  initial begin
    #1000000;
    mismatches++;
    final_report();
  end
endmodule : testbench
